// file: design/gqd_top.sv
/*
 * port input filter select, sample period and pin direction control for a
 * 64-pin general purpose port, with a classic wishbone register slave.
 * assumes pins arrive asynchronously and peripheral signals on REF_CLK.
 */
// Function
// - each filter select word holds sixteen 2-bit fields, one per pin.
// - upper port A, lower and upper port B words cover pins sixteen apiece.
// - code 00 only synchronises the input, for general I/O and peripherals.
// - code 01 accepts a change after three equal samples at the period.
// - code 10 accepts a change after six equal samples at the period.
// - code 11 passes the raw pin to a peripheral without synchronising.
// - code 11 on a general-purpose input behaves like code 00.
// - filter select words only take writes while write permission is set.
// - a direction bit steers its pin only while the pin is general I/O.
// - direction bits never affect pins owned by a peripheral.
// - direction 0 is input, 1 drives the output latch onto the pin.
// - sample period per eight pins: code 0 one clock, else twice the code.
`timescale 1ns/100ps
`default_nettype none
module gqd_top #(
	parameter int NPINS = gqd_pkg::NUM_PINS
) (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [63:0] PIN_IN,
	output logic [63:0] PIN_OUT,
	output logic [63:0] PIN_OE,
	input wire logic [63:0] PERIPH_OUT,
	input wire logic [63:0] PERIPH_OE,
	output logic [63:0] PERIPH_IN
);
	localparam int NG = gqd_pkg::NUM_GROUPS;
	localparam int GW = gqd_pkg::GROUP_PINS;

	if (NPINS != gqd_pkg::NUM_PINS) begin : g_bad_npins
		$error("gqd_top serves exactly 64 pins");
	end

	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	function automatic logic [gqd_pkg::PRD_CNT_W-1:0] period_clks(
		input logic [gqd_pkg::PRD_FIELD_W-1:0] code);
		logic [gqd_pkg::PRD_CNT_W-1:0] r;
		r = (code == '0) ? gqd_pkg::PRD_CNT_W'(1) : {code, 1'b0};
		return r;
	endfunction

	// registers
	logic protect_q;
	logic [3:0][31:0] qsel_q;
	logic [1:0][31:0] period_q;
	logic [1:0][31:0] mux_q;
	logic [1:0][31:0] dir_q;
	logic [1:0][31:0] dout_q;
	logic ack_q;
	logic [31:0] rdata_q;

	wire logic req = WB_CYC_I && WB_STB_I;
	wire logic wr_now = req && WB_WE_I && ack_q;
	wire logic [63:0] mux_all = {mux_q[1], mux_q[0]};
	wire logic [63:0] dir_all = {dir_q[1], dir_q[0]};
	wire logic [63:0] dout_all = {dout_q[1], dout_q[0]};

	// bus handshake: ack one cycle after the request, writes land at the acked edge
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) ack_q <= 1'b0;
		else ack_q <= req && !ack_q;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) protect_q <= gqd_pkg::RST_PROTECT;
		else if (wr_now && WB_ADR_I == gqd_pkg::ADR_PROTECT && WB_SEL_I[0])
			protect_q <= WB_DAT_I[gqd_pkg::PROTECT_BIT];
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			qsel_q <= {4{gqd_pkg::RST_QSEL}};
		end else if (wr_now && protect_q) begin
			case (WB_ADR_I)
				gqd_pkg::ADR_A_LOWER_QSEL: qsel_q[0] <= merge_sel(qsel_q[0], WB_DAT_I, WB_SEL_I);
				gqd_pkg::ADR_A_UPPER_QSEL: qsel_q[1] <= merge_sel(qsel_q[1], WB_DAT_I, WB_SEL_I);
				gqd_pkg::ADR_B_LOWER_QSEL: qsel_q[2] <= merge_sel(qsel_q[2], WB_DAT_I, WB_SEL_I);
				gqd_pkg::ADR_B_UPPER_QSEL: qsel_q[3] <= merge_sel(qsel_q[3], WB_DAT_I, WB_SEL_I);
				default: qsel_q <= qsel_q;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			period_q <= {2{gqd_pkg::RST_PERIOD}};
			mux_q <= {2{gqd_pkg::RST_MUX}};
			dir_q <= {2{gqd_pkg::RST_DIR}};
		end else if (wr_now && protect_q) begin
			case (WB_ADR_I)
				gqd_pkg::ADR_A_PERIOD: period_q[0] <= merge_sel(period_q[0], WB_DAT_I, WB_SEL_I);
				gqd_pkg::ADR_B_PERIOD: period_q[1] <= merge_sel(period_q[1], WB_DAT_I, WB_SEL_I);
				gqd_pkg::ADR_A_MUX: mux_q[0] <= merge_sel(mux_q[0], WB_DAT_I, WB_SEL_I);
				gqd_pkg::ADR_B_MUX: mux_q[1] <= merge_sel(mux_q[1], WB_DAT_I, WB_SEL_I);
				gqd_pkg::ADR_A_DIR: dir_q[0] <= merge_sel(dir_q[0], WB_DAT_I, WB_SEL_I);
				gqd_pkg::ADR_B_DIR: dir_q[1] <= merge_sel(dir_q[1], WB_DAT_I, WB_SEL_I);
				default: dir_q <= dir_q;
			endcase
		end
	end

	// output latch is not behind the permission bit
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			dout_q <= {2{gqd_pkg::RST_DOUT}};
		end else if (wr_now) begin
			case (WB_ADR_I)
				gqd_pkg::ADR_A_DOUT: dout_q[0] <= merge_sel(dout_q[0], WB_DAT_I, WB_SEL_I);
				gqd_pkg::ADR_B_DOUT: dout_q[1] <= merge_sel(dout_q[1], WB_DAT_I, WB_SEL_I);
				default: dout_q <= dout_q;
			endcase
		end
	end

	// pin synchronisers
	logic [63:0] sync1_q;
	logic [63:0] sync2_q;
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= PIN_IN;
			sync2_q <= sync1_q;
		end
	end

	// sample period dividers, one per eight pins
	logic [NG-1:0][gqd_pkg::PRD_CNT_W-1:0] cnt_q;
	logic [NG-1:0] strobe;
	logic [63:0] qual;

	for (genvar g = 0; g < NG; g++) begin : g_grp
		wire logic [gqd_pkg::PRD_FIELD_W-1:0] code =
			period_q[g/4][gqd_pkg::PRD_FIELD_W*(g%4) +: gqd_pkg::PRD_FIELD_W];
		assign strobe[g] = (cnt_q[g] == '0);

		always_ff @(posedge REF_CLK) begin
			if (!RESETN) cnt_q[g] <= '0;
			else if (strobe[g]) cnt_q[g] <= period_clks(code) - 1'b1;
			else cnt_q[g] <= cnt_q[g] - 1'b1;
		end

		gqd_qual_if #(.W(GW)) qi ();
		assign qi.raw = sync2_q[GW*g +: GW];
		// sixteen 2-bit fields per word, low pin at low bits
		assign qi.mode = qsel_q[g/2][2*GW*(g%2) +: 2*GW];
		assign qi.strobe = strobe[g];
		assign qual[GW*g +: GW] = qi.qual;

		gqd_qual #(.W(GW)) u_qual (
			.clk(REF_CLK),
			.rst_n(RESETN),
			.q(qi.filt)
		);
	end

	// pin drive and peripheral input
	logic [63:0] pin_out_q;
	logic [63:0] pin_oe_q;
	logic [63:0] periph_qual_q;
	logic [63:0] async_sel;

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			pin_out_q <= '0;
			pin_oe_q <= '0;
		end else begin
			for (int i = 0; i < 64; i++) begin
				if (mux_all[i]) begin
					pin_out_q[i] <= PERIPH_OUT[i];
					pin_oe_q[i] <= PERIPH_OE[i];
				end else begin
					pin_out_q[i] <= dout_all[i];
					pin_oe_q[i] <= dir_all[i];
				end
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) periph_qual_q <= '0;
		else periph_qual_q <= qual;
	end

	always_comb begin
		for (int i = 0; i < 64; i++) begin
			async_sel[i] = mux_all[i] && (qsel_q[i/16][2*(i%16) +: 2] == 2'h3);
		end
	end

	// async bypass is a raw path from pin to peripheral
	assign PERIPH_IN = (async_sel & PIN_IN) | (~async_sel & periph_qual_q);
	assign PIN_OUT = pin_out_q;
	assign PIN_OE = pin_oe_q;

	// read path
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			rdata_q <= '0;
		end else if (req && !ack_q && !WB_WE_I) begin
			case (WB_ADR_I)
				gqd_pkg::ADR_PROTECT: rdata_q <= {31'h0, protect_q};
				gqd_pkg::ADR_A_LOWER_QSEL: rdata_q <= qsel_q[0];
				gqd_pkg::ADR_A_UPPER_QSEL: rdata_q <= qsel_q[1];
				gqd_pkg::ADR_B_LOWER_QSEL: rdata_q <= qsel_q[2];
				gqd_pkg::ADR_B_UPPER_QSEL: rdata_q <= qsel_q[3];
				gqd_pkg::ADR_A_PERIOD: rdata_q <= period_q[0];
				gqd_pkg::ADR_B_PERIOD: rdata_q <= period_q[1];
				gqd_pkg::ADR_A_MUX: rdata_q <= mux_q[0];
				gqd_pkg::ADR_B_MUX: rdata_q <= mux_q[1];
				gqd_pkg::ADR_A_DIR: rdata_q <= dir_q[0];
				gqd_pkg::ADR_B_DIR: rdata_q <= dir_q[1];
				gqd_pkg::ADR_A_DOUT: rdata_q <= dout_q[0];
				gqd_pkg::ADR_B_DOUT: rdata_q <= dout_q[1];
				gqd_pkg::ADR_A_PIN_IN: rdata_q <= qual[31:0];
				gqd_pkg::ADR_B_PIN_IN: rdata_q <= qual[63:32];
				default: rdata_q <= '0;
			endcase
		end
	end

	assign WB_DAT_O = rdata_q;
	assign WB_ACK_O = ack_q;

	// checks
	// spacing is measured on the group of pins 48 to 55
	logic [gqd_pkg::PRD_CNT_W-1:0] since_q;
	logic [gqd_pkg::PRD_FIELD_W-1:0] load_code_q;
	always_ff @(posedge REF_CLK) begin
		if (!RESETN || strobe[6]) since_q <= gqd_pkg::PRD_CNT_W'(1);
		else since_q <= since_q + 1'b1;
	end

	// code the divider reloaded with at the last strobe
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) load_code_q <= '0;
		else if (strobe[6]) load_code_q <= period_q[1][23:16];
	end

	sequence s_prot_write;
		wr_now && !protect_q;
	endsequence

	sequence s_req_ack;
		req && !ack_q ##1 ack_q;
	endsequence

	sequence s_dir_read;
		req && !ack_q && !WB_WE_I && WB_ADR_I == gqd_pkg::ADR_A_DIR;
	endsequence

	// register bus

	protect_block_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_prot_write |=> $stable(qsel_q))
		else $error("protected filter select changed without permission");
	setup_lock_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_prot_write |=> ($stable(period_q) && $stable(mux_q) && $stable(dir_q)))
		else $error("protected setup register changed without permission");
	qsel_accept_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(wr_now && protect_q && WB_ADR_I == gqd_pkg::ADR_B_UPPER_QSEL && WB_SEL_I == 4'hf)
		|=> (qsel_q[3] == $past(WB_DAT_I)))
		else $error("permitted filter select write did not land");
	latch_write_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(wr_now && WB_ADR_I == gqd_pkg::ADR_A_DOUT && WB_SEL_I == 4'hf)
		|=> (dout_q[0] == $past(WB_DAT_I)))
		else $error("output latch write did not land");
	ack_answer_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(req && !ack_q) |=> ack_q)
		else $error("request not acknowledged in the next cycle");
	dir_read_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_dir_read |=> (ack_q && WB_DAT_O == $past(dir_q[0])))
		else $error("direction read returned wrong data");
	zero_read_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(req && !ack_q && !WB_WE_I && WB_ADR_I == 8'hfc) |=> (WB_DAT_O == 32'h0000_0000))
		else $error("unmapped read not zero");

	// pin paths
	reset_zero_a: assert property (@(posedge REF_CLK)
		$rose(RESETN) |-> (qsel_q == '0 && dir_q == '0))
		else $error("select or direction not zero after reset");
	gpio_dir_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(!mux_all[3] && $stable(mux_all[3])) |=> (PIN_OE[3] == $past(dir_all[3])))
		else $error("direction bit did not steer general pin");
	periph_owns_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		mux_all[1] |=> (PIN_OE[1] == $past(PERIPH_OE[1])
		&& PIN_OUT[1] == $past(PERIPH_OUT[1])))
		else $error("direction bit affected peripheral pin");
	drive_latch_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(!mux_all[0] && dir_all[0]) |=> (PIN_OE[0] && PIN_OUT[0] == $past(dout_all[0])))
		else $error("output pin not driving latch value");
	bypass_raw_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		async_sel[33] |-> (PERIPH_IN[33] == PIN_IN[33]))
		else $error("async peripheral input not bypassed");
	pin_reset_a: assert property (@(posedge REF_CLK)
		$rose(RESETN) |-> (PIN_OE == '0 && WB_ACK_O == 1'b0))
		else $error("pins or ack not idle after reset");
	// a pin reaches the filters two flops after it changes
	sync_chain_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		($past(RESETN) && $past(RESETN, 2)) |-> (sync2_q == $past(PIN_IN, 2)))
		else $error("pin synchroniser depth wrong");
	periph_reg_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		($past(RESETN) && !async_sel[32]) |-> (PERIPH_IN[32] == $past(qual[32])))
		else $error("filtered peripheral input not one cycle behind");

	// divider and ack pulse
	period_space_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		strobe[6] |-> (since_q == period_clks(load_code_q)))
		else $error("sample spacing wrong");
	strobe_fast_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(strobe[7] && period_q[1][31:24] == 8'h00) |=> strobe[7])
		else $error("code zero did not sample every clock");
	cnt_bound_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		cnt_q[6] < period_clks(load_code_q))
		else $error("divider count above its period");
	ack_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_req_ack |=> !ack_q)
		else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// file: design/gqd_pkg.sv
/*
 * constants and types for the port input filter and direction block.
 * assumes a 32-bit classic wishbone register bus and a 50 MHz system clock.
 */
package gqd_pkg;
	localparam int NUM_PINS = 64;
	localparam int GROUP_PINS = 8;
	localparam int NUM_GROUPS = NUM_PINS / GROUP_PINS;
	localparam int FIELD_PINS = 16;
	localparam int FIELD_W = 2;

	localparam int SAMP3_N = 3;
	localparam int SAMP6_N = 6;
	localparam int HIST_W = SAMP6_N;

	// sample period field: 8 bits per group of eight pins, four per control word
	localparam int PRD_FIELD_W = 8;
	localparam int PRD_CNT_W = 9;
	localparam int PRD_MAX_CLK = 510;

	localparam int CLK_FREQ_HZ = 50_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;

	typedef enum logic [1:0] {
		GQD_SYNC = 2'h0,
		GQD_SAMP3 = 2'h1,
		GQD_SAMP6 = 2'h2,
		GQD_ASYNC = 2'h3
	} gqd_qmode_e;

	localparam logic [7:0] ADR_PROTECT = 8'h00;
	localparam logic [7:0] ADR_A_LOWER_QSEL = 8'h04;
	localparam logic [7:0] ADR_A_UPPER_QSEL = 8'h08;
	localparam logic [7:0] ADR_B_LOWER_QSEL = 8'h0c;
	localparam logic [7:0] ADR_B_UPPER_QSEL = 8'h10;
	localparam logic [7:0] ADR_A_PERIOD = 8'h14;
	localparam logic [7:0] ADR_B_PERIOD = 8'h18;
	localparam logic [7:0] ADR_A_MUX = 8'h1c;
	localparam logic [7:0] ADR_B_MUX = 8'h20;
	localparam logic [7:0] ADR_A_DIR = 8'h24;
	localparam logic [7:0] ADR_B_DIR = 8'h28;
	localparam logic [7:0] ADR_A_DOUT = 8'h2c;
	localparam logic [7:0] ADR_B_DOUT = 8'h30;
	localparam logic [7:0] ADR_A_PIN_IN = 8'h34;
	localparam logic [7:0] ADR_B_PIN_IN = 8'h38;

	localparam int PROTECT_BIT = 0;
	localparam logic [31:0] RST_QSEL = 32'h0000_0000;
	localparam logic [31:0] RST_DIR = 32'h0000_0000;
	localparam logic [31:0] RST_PERIOD = 32'h0000_0000;
	localparam logic [31:0] RST_MUX = 32'h0000_0000;
	localparam logic [31:0] RST_DOUT = 32'h0000_0000;
	localparam logic RST_PROTECT = 1'b0;
endpackage

// file: design/gqd_qual_if.sv
/*
 * carrier between the top level and one group of pin filters.
 * assumes both ends sit on the same system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface gqd_qual_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [2*W-1:0] mode;
	logic strobe;
	logic [W-1:0] qual;
	modport ctl (output raw, output mode, output strobe, input qual);
	modport filt (input raw, input mode, input strobe, output qual);
endinterface
`default_nettype wire

// file: design/gqd_qual.sv
/*
 * input filter for one group of pins: pass-through, 3-sample or 6-sample.
 * assumes raw inputs are already synchronised and strobe marks each sample.
 */
`timescale 1ns/100ps
`default_nettype none
module gqd_qual #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	gqd_qual_if.filt q
);
	logic [W-1:0][gqd_pkg::HIST_W-1:0] hist_q;
	logic [W-1:0] qual_q;

	if (W < 1) begin : g_bad_width
		$error("gqd_qual needs at least one pin");
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hist_q <= '0;
		end else if (q.strobe) begin
			for (int i = 0; i < W; i++) begin
				hist_q[i] <= {hist_q[i][gqd_pkg::HIST_W-2:0], q.raw[i]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			qual_q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				case (gqd_pkg::gqd_qmode_e'(q.mode[2*i +: 2]))
					gqd_pkg::GQD_SAMP3: begin
						if (&hist_q[i][gqd_pkg::SAMP3_N-1:0]) qual_q[i] <= 1'b1;
						else if (~|hist_q[i][gqd_pkg::SAMP3_N-1:0]) qual_q[i] <= 1'b0;
					end
					gqd_pkg::GQD_SAMP6: begin
						if (&hist_q[i]) qual_q[i] <= 1'b1;
						else if (~|hist_q[i]) qual_q[i] <= 1'b0;
					end
					// async code filters like sync here
					default: qual_q[i] <= q.raw[i];
				endcase
			end
		end
	end

	assign q.qual = qual_q;

	for (genvar i = 0; i < W; i++) begin : g_chk
		wire logic [1:0] md = q.mode[2*i +: 2];
		sync_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
			(md == 2'h0) |=> (q.qual[i] == $past(q.raw[i])))
			else $error("sync mode did not follow input");
		async_as_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
			(md == 2'h3) |=> (q.qual[i] == $past(q.raw[i])))
			else $error("async code not filtered like sync");
		samp3_accept_a: assert property (@(posedge clk) disable iff (!rst_n)
			(md == 2'h1 && $stable(md) && hist_q[i][2:0] == 3'h7) |=> q.qual[i])
			else $error("three high samples not accepted");
		samp6_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
			(md == 2'h2 && $stable(md) && hist_q[i] != '0 && hist_q[i] != '1)
			|=> $stable(q.qual[i]))
			else $error("six-sample filter changed on mixed samples");
	end
endmodule
`default_nettype wire

// file: sim/gqd_pin_model.sv
/*
 * behavioural model of the pads and board around the 64-pin port.
 * assumes the bench supplies the external level and whether the board drives it.
 */
`timescale 1ns/100ps
`default_nettype none
module gqd_pin_model (
	input wire logic [63:0] pin_out,
	input wire logic [63:0] pin_oe,
	input wire logic [63:0] ext_val,
	input wire logic [63:0] ext_en,
	output logic [63:0] pin_in
);
	// the device drive wins; an undriven pad floats up through its pull-up
	always_comb begin
		pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
	end
endmodule
`default_nettype wire

// file: sim/tb.sv
/*
 * self-checking bench for the port filter and direction block.
 * assumes gqd_pkg, gqd_top and gqd_pin_model are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack;
	logic [63:0] pin_in;
	logic [63:0] pin_out;
	logic [63:0] pin_oe;
	logic [63:0] periph_in;
	logic [63:0] periph_out = 64'h0000_0000_0000_0002;
	logic [63:0] periph_oe = 64'h0000_0000_0000_0002;
	logic [63:0] ext_val = 64'h0000_0000_0000_0000;
	logic [63:0] ext_en = 64'hffff_ffff_ffff_ffff;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] xfer_q;

	always #10 ref_clk = ~ref_clk;

	gqd_top u_dut (
		.REF_CLK(ref_clk),
		.RESETN(resetn),
		.WB_CYC_I(wb_cyc),
		.WB_STB_I(wb_stb),
		.WB_WE_I(wb_we),
		.WB_ADR_I(wb_adr),
		.WB_SEL_I(wb_sel),
		.WB_DAT_I(wb_dat_i),
		.WB_DAT_O(wb_dat_o),
		.WB_ACK_O(wb_ack),
		.PIN_IN(pin_in),
		.PIN_OUT(pin_out),
		.PIN_OE(pin_oe),
		.PERIPH_OUT(periph_out),
		.PERIPH_OE(periph_oe),
		.PERIPH_IN(periph_in)
	);

	gqd_pin_model u_pins (
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.ext_val(ext_val),
		.ext_en(ext_en),
		.pin_in(pin_in)
	);

	task automatic give_verdict;
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_pin(input string name, input logic [63:0] mask, input logic [63:0] exp,
			input logic [63:0] got);
		checks_done++;
		if ((got & mask) !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got & mask);
		end
	endtask

	// one classic cycle: request held until ack is seen at a rising edge
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
			input logic [31:0] dat, output logic [31:0] q);
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= sel;
		wb_dat_i <= dat;
		@(posedge ref_clk);
		while (wb_ack !== 1'b1) @(posedge ref_clk);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] q;
		wb_xfer(1'b1, adr, 4'hf, dat, q);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] q;
		wb_xfer(1'b0, adr, 4'hf, 32'h0000_0000, q);
		chk_reg(name, exp, q);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// hang guard, the whole sequence needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rd_chk("a_upper_sel", gqd_pkg::ADR_A_UPPER_QSEL, 32'h0000_0000);
		rd_chk("b_lower_sel", gqd_pkg::ADR_B_LOWER_QSEL, 32'h0000_0000);
		rd_chk("b_upper_sel", gqd_pkg::ADR_B_UPPER_QSEL, 32'h0000_0000);
		rd_chk("a_dir", gqd_pkg::ADR_A_DIR, 32'h0000_0000);
		wr(gqd_pkg::ADR_B_LOWER_QSEL, 32'hffff_ffff);
		rd_chk("b_lower_locked", gqd_pkg::ADR_B_LOWER_QSEL, 32'h0000_0000);
		wr(gqd_pkg::ADR_PROTECT, 32'h0000_0001);
		wr(gqd_pkg::ADR_B_UPPER_QSEL, 32'h1234_abcd);
		rd_chk("b_upper_rw", gqd_pkg::ADR_B_UPPER_QSEL, 32'h1234_abcd);
		wb_xfer(1'b1, gqd_pkg::ADR_B_UPPER_QSEL, 4'h2, 32'hffff_56ff, xfer_q);
		rd_chk("b_upper_merge", gqd_pkg::ADR_B_UPPER_QSEL, 32'h1234_56cd);
		rd_chk("unmapped", 8'hfc, 32'h0000_0000);
		// pin48 six samples, pin49 three samples, pin56 six samples
		wr(gqd_pkg::ADR_B_UPPER_QSEL, 32'h0002_0006);
		// pin32 sync only, pins 33 and 34 asynchronous code
		wr(gqd_pkg::ADR_B_LOWER_QSEL, 32'h0000_003c);
		wr(gqd_pkg::ADR_B_PERIOD, 32'h0003_0000);
		wr(gqd_pkg::ADR_B_MUX, 32'h0000_0002);
		rd_chk("b_lower_rw", gqd_pkg::ADR_B_LOWER_QSEL, 32'h0000_003c);
		@(posedge ref_clk);
		ext_val[34:32] <= 3'h7;
		#1;
		chk_pin("async_now", 64'h0000_0007_0000_0000, 64'h0000_0002_0000_0000, periph_in);
		settle(2);
		chk_pin("sync_hold", 64'h0000_0007_0000_0000, 64'h0000_0002_0000_0000, periph_in);
		settle(4);
		chk_pin("sync_pass", 64'h0000_0007_0000_0000, 64'h0000_0007_0000_0000, periph_in);
		rd_chk("b_readback", gqd_pkg::ADR_B_PIN_IN, 32'h0000_0007);
		@(posedge ref_clk);
		ext_val[56] <= 1'b1;
		ext_val[49:48] <= 2'h3;
		settle(26);
		chk_pin("filt_early", 64'h0103_0000_0000_0000, 64'h0102_0000_0000_0000, periph_in);
		settle(20);
		chk_pin("filt_late", 64'h0103_0000_0000_0000, 64'h0103_0000_0000_0000, periph_in);
		wr(gqd_pkg::ADR_A_DOUT, 32'h0000_0005);
		wr(gqd_pkg::ADR_A_DIR, 32'h0000_000f);
		rd_chk("a_dir_rw", gqd_pkg::ADR_A_DIR, 32'h0000_000f);
		settle(2);
		chk_pin("gpio_drive", 64'h0000_0000_ffff_ffff, 64'h0000_0000_0000_000f, pin_oe);
		chk_pin("gpio_value", 64'h0000_0000_0000_000f, 64'h0000_0000_0000_0005, pin_out);
		wr(gqd_pkg::ADR_A_MUX, 32'h0000_0003);
		settle(2);
		chk_pin("periph_own", 64'h0000_0000_0000_000f, 64'h0000_0000_0000_000e, pin_oe);
		chk_pin("periph_value", 64'h0000_0000_0000_0003, 64'h0000_0000_0000_0002, pin_out);
		wr(gqd_pkg::ADR_A_DIR, 32'h0000_0000);
		settle(2);
		chk_pin("dir_clear", 64'h0000_0000_0000_000f, 64'h0000_0000_0000_0002, pin_oe);
		wr(gqd_pkg::ADR_PROTECT, 32'h0000_0000);
		wr(gqd_pkg::ADR_A_DIR, 32'hffff_ffff);
		rd_chk("a_dir_locked", gqd_pkg::ADR_A_DIR, 32'h0000_0000);
		give_verdict();
	end
endmodule
`default_nettype wire
